// *** logic/ptcfg_decode.sv ***
`timescale 1ns/1ps
// Turns one stored configuration into the per-path payload structure.
module ptcfg_decode
   import ptcfg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input ptcfg_cfg_s cfg,
   output ptcfg_path_s paths
);
   ptcfg_path_s paths_r; // Registered structure.
   ptcfg_path_s paths_nxt; // Its next value.
   ptcfg_kind_e [NUM_PATHS-1:0] kind_c; // Per-path kinds.

   // Each path takes its kind from the twelve-path bit, else from the group that it belongs to.
   for (genvar p = 0; p < NUM_PATHS; p++) begin : g_path
      always_comb begin
         if (cfg.twelve) begin
            kind_c[p] = KIND_TWELVE;
         end else if (cfg.group[p % GROUPS]) begin
            kind_c[p] = KIND_GROUP3;
         end else begin
            kind_c[p] = KIND_STS1;
         end
      end
   end

   // Span decode; invalid codes are flagged rather than guessed at.
   always_comb begin
      paths_nxt = '0;
      paths_nxt.kind = kind_c;
      paths_nxt.slave = cfg.slave & cfg.twelve;
      paths_nxt.span_bad = 1'b0;
      if (!cfg.twelve) begin
         paths_nxt.units = UNITS_ONE;
      end else begin
         unique case (cfg.span)
            SPAN_SINGLE: paths_nxt.units = UNITS_ONE;
            SPAN_TWO: paths_nxt.units = UNITS_TWO;
            SPAN_THREE: paths_nxt.units = UNITS_THREE;
            SPAN_FOUR: paths_nxt.units = UNITS_FOUR;
            default: begin
               paths_nxt.units = UNITS_BAD;
               paths_nxt.span_bad = 1'b1;
            end
         endcase
      end
   end

   // The structure is registered so the datapath sees clean levels.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         paths_r <= '0;
      end else begin
         paths_r <= paths_nxt;
      end
   end

   assign paths = paths_r;

   a_group_join: assert property (
      @(posedge clk) disable iff (rst)
      (!cfg.twelve && cfg.group[0]) |=>
         (paths.kind[0] == KIND_GROUP3 && paths.kind[4] == KIND_GROUP3
          && paths.kind[8] == KIND_GROUP3 && paths.kind[1] != KIND_TWELVE))
      else $error("group bit did not join its three paths");
   a_span_units: assert property (
      @(posedge clk) disable iff (rst)
      (cfg.twelve && cfg.span == SPAN_FOUR) |=>
         (paths.units == UNITS_FOUR && !paths.span_bad))
      else $error("span code three did not give four units");
   a_span_bad: assert property (
      @(posedge clk) disable iff (rst)
      (cfg.twelve && cfg.span[2]) |=> paths.span_bad)
      else $error("invalid span code not flagged");
   a_twelve_all: assert property (
      @(posedge clk) disable iff (rst)
      cfg.twelve |=> (paths.kind == {NUM_PATHS{KIND_TWELVE}}))
      else $error("twelve-path concat did not cover all paths");
endmodule // ptcfg_decode

// *** logic/ptcfg_pkg.sv ***
// How it works
// - Group bit n joins paths n, n+4, n+8.
// - Span field 0..3 chains 1..4 units, rest invalid.
// - Twelve-path concat makes one chained payload.
// - Without twelve-path concat, group bits decide.
// - Role bit one means slave portion, only with twelve-path concat.
// - Locked path byte mismatch sets its flag.
// - Flags latch regardless, clear after read.
// - Per-path enable routes byte error to interrupt.
// - Parity flag sets only on comparison change.
// - Slice copies 0x400 apart, gated by selects.
// - Per-path enable routes parity change to interrupt.
// - Lock state from per-path monitor qualifies events.
package ptcfg_pkg;
   localparam int NUM_PATHS = 12;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 12;
   localparam int GROUPS = 4;
   // Offsets of the registers inside one slice (low ten address bits).
   localparam logic [9:0] OFS_GEN_CFG = 10'h242;
   localparam logic [9:0] OFS_CHK_CFG = 10'h243;
   localparam logic [9:0] OFS_ERR_FLAG = 10'h244;
   localparam logic [9:0] OFS_ERR_EN = 10'h245;
   localparam logic [9:0] OFS_PAR_FLAG = 10'h246;
   localparam logic [9:0] OFS_PAR_EN = 10'h247;
   // Slice number sits above the in-slice offset, so slices are 0x400 apart.
   localparam int SLICE_POS = 10;
   // Field positions of the payload configuration words.
   localparam int SLAVE_POS = 15;
   localparam int TWELVE_POS = 14;
   localparam int SPAN_POS = 8;
   localparam int RSVD_POS = 6;
   localparam int GROUP_POS = 0;
   // Chain span codes and the unit counts they stand for.
   localparam logic [2:0] SPAN_SINGLE = 3'h0;
   localparam logic [2:0] SPAN_TWO = 3'h1;
   localparam logic [2:0] SPAN_THREE = 3'h2;
   localparam logic [2:0] SPAN_FOUR = 3'h3;
   localparam logic [2:0] UNITS_ONE = 3'h1;
   localparam logic [2:0] UNITS_TWO = 3'h2;
   localparam logic [2:0] UNITS_THREE = 3'h3;
   localparam logic [2:0] UNITS_FOUR = 3'h4;
   localparam logic [2:0] UNITS_BAD = 3'h0;
   // Reset values.
   localparam logic [NUM_PATHS-1:0] PATHS_RST = 12'h000;
   localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
   // Payload structure of one path.
   typedef enum logic [1:0] {
      KIND_STS1 = 2'h0,
      KIND_GROUP3 = 2'h1,
      KIND_TWELVE = 2'h3
   } ptcfg_kind_e;
   // Stored payload configuration of the generator or the checker.
   typedef struct packed {
      logic slave;
      logic twelve;
      logic [2:0] span;
      logic rsvd;
      logic [GROUPS-1:0] group;
   } ptcfg_cfg_s;
   localparam ptcfg_cfg_s CFG_RST = '0;
   // Decoded structure handed to the datapath.
   typedef struct packed {
      ptcfg_kind_e [NUM_PATHS-1:0] kind;
      logic [2:0] units;
      logic span_bad;
      logic slave;
   } ptcfg_path_s;
   // Per-path events from the checker datapath.
   typedef struct packed {
      logic [NUM_PATHS-1:0] locked;
      logic [NUM_PATHS-1:0] byte_err;
      logic [NUM_PATHS-1:0] cmp_valid;
      logic [NUM_PATHS-1:0] cmp_mismatch;
   } ptcfg_evt_s;
endpackage

// *** logic/ptcfg_top.sv ***
`timescale 1ns/1ps
// Payload configuration and event flags of one pattern tester slice.
module ptcfg_top
   import ptcfg_pkg::*;
#(
   parameter logic [1:0] SLICE_ID = 2'h0
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] d_in,
   output logic [DATA_W-1:0] d_out,
   output logic d_oe,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic test_reg_select_n,
   input wire logic block_select_n,
   input ptcfg_evt_s evt,
   output ptcfg_path_s gen_paths,
   output ptcfg_path_s chk_paths,
   output logic irq
);
   // Address decode.
   logic sel; // This slice is addressed.
   logic hit_gen; // Generator configuration.
   logic hit_chk; // Checker configuration.
   logic hit_err; // Byte error flags.
   logic hit_erren; // Byte error enables.
   logic hit_par; // Parity change flags.
   logic hit_paren; // Parity change enables.
   logic hit_any; // Any mapped register.
   logic rd_act; // A read is in progress this cycle.
   logic wr_fire; // One-cycle write strike.

   // Bus state.
   logic wr_n_r; // Write strobe of the last cycle.
   logic rd_act_r; // Read active in the last cycle.
   logic rd_err_r; // Last read showed the byte error flags.
   logic rd_par_r; // Last read showed the parity flags.
   logic [NUM_PATHS-1:0] snap_r; // Flag bits shown by the last read.
   logic [DATA_W-1:0] rd_data_r; // Read data held for the pins.
   // Next values of the bus state.
   logic wr_n_nxt;
   logic rd_act_nxt;
   logic rd_err_nxt;
   logic rd_par_nxt;
   logic [NUM_PATHS-1:0] snap_nxt;
   logic [DATA_W-1:0] rd_data_nxt;

   // Configuration and enables.
   ptcfg_cfg_s gen_cfg_r; // Generator payload configuration.
   ptcfg_cfg_s chk_cfg_r; // Checker payload configuration.
   logic [NUM_PATHS-1:0] err_en_r; // Byte error interrupt enables.
   logic [NUM_PATHS-1:0] par_en_r; // Parity change interrupt enables.
   // Next values of the configuration registers.
   ptcfg_cfg_s gen_cfg_nxt;
   ptcfg_cfg_s chk_cfg_nxt;
   logic [NUM_PATHS-1:0] err_en_nxt;
   logic [NUM_PATHS-1:0] par_en_nxt;

   // Event flags.
   logic [NUM_PATHS-1:0] err_flag_r; // path_byte_error_flag per path.
   logic [NUM_PATHS-1:0] par_flag_r; // path_parity_change_flag per path.
   logic [NUM_PATHS-1:0] last_mis_r; // Last comparison was a mismatch.
   logic irq_r; // Registered interrupt level.
   // Next values of the flag registers.
   logic [NUM_PATHS-1:0] err_flag_nxt;
   logic [NUM_PATHS-1:0] par_flag_nxt;
   logic [NUM_PATHS-1:0] last_mis_nxt;
   logic irq_nxt;
   // Per-path decisions of the current cycle.
   logic [NUM_PATHS-1:0] err_set; // Byte error events this cycle.
   logic [NUM_PATHS-1:0] par_set; // Parity change events this cycle.
   logic [NUM_PATHS-1:0] clr_err; // Bits cleared by a finished read.
   logic [NUM_PATHS-1:0] clr_par;

   // Packs a configuration into its register word; unused bits read zero.
   function automatic logic [DATA_W-1:0] cfg_word(input ptcfg_cfg_s c);
      logic [DATA_W-1:0] w;
      w = WORD_RST;
      w[SLAVE_POS] = c.slave;
      w[TWELVE_POS] = c.twelve;
      w[SPAN_POS +: 3] = c.span;
      w[RSVD_POS] = c.rsvd;
      w[GROUP_POS +: GROUPS] = c.group;
      return w;
   endfunction

   // Unpacks a written word into a configuration.
   function automatic ptcfg_cfg_s word_cfg(input logic [DATA_W-1:0] w);
      ptcfg_cfg_s c;
      c.slave = w[SLAVE_POS];
      c.twelve = w[TWELVE_POS];
      c.span = w[SPAN_POS +: 3];
      c.rsvd = w[RSVD_POS];
      c.group = w[GROUP_POS +: GROUPS];
      return c;
   endfunction

   // Selection and register decode; only this slice's copy answers.
   always_comb begin
      sel = test_reg_select_n && !block_select_n
         && (addr[ADDR_W-1:SLICE_POS] == SLICE_ID);
      hit_gen = sel && (addr[SLICE_POS-1:0] == OFS_GEN_CFG);
      hit_chk = sel && (addr[SLICE_POS-1:0] == OFS_CHK_CFG);
      hit_err = sel && (addr[SLICE_POS-1:0] == OFS_ERR_FLAG);
      hit_erren = sel && (addr[SLICE_POS-1:0] == OFS_ERR_EN);
      hit_par = sel && (addr[SLICE_POS-1:0] == OFS_PAR_FLAG);
      hit_paren = sel && (addr[SLICE_POS-1:0] == OFS_PAR_EN);
      hit_any = hit_gen | hit_chk | hit_err | hit_erren | hit_par
         | hit_paren;
      rd_act = hit_any && !rd_n;
      // A write strikes once, on the cycle its strobe first goes low.
      wr_fire = sel && !wr_n && wr_n_r;
   end

   // Read path: data is sampled every cycle of the read so the last
   // value shown is exactly the one whose flags get cleared.
   always_comb begin
      wr_n_nxt = wr_n;
      rd_act_nxt = rd_act;
      rd_err_nxt = rd_act && hit_err;
      rd_par_nxt = rd_act && hit_par;
      snap_nxt = snap_r;
      rd_data_nxt = rd_data_r;
      if (rd_act) begin
         rd_data_nxt = WORD_RST;
         snap_nxt = PATHS_RST;
         if (hit_gen) begin
            rd_data_nxt = cfg_word(gen_cfg_r);
         end else if (hit_chk) begin
            rd_data_nxt = cfg_word(chk_cfg_r);
         end else if (hit_err) begin
            rd_data_nxt[NUM_PATHS-1:0] = err_flag_r;
            snap_nxt = err_flag_r;
         end else if (hit_erren) begin
            rd_data_nxt[NUM_PATHS-1:0] = err_en_r;
         end else if (hit_par) begin
            rd_data_nxt[NUM_PATHS-1:0] = par_flag_r;
            snap_nxt = par_flag_r;
         end else begin
            rd_data_nxt[NUM_PATHS-1:0] = par_en_r;
         end
      end
   end

   // Bus registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_n_r <= 1'b1;
         rd_act_r <= 1'b0;
         rd_err_r <= 1'b0;
         rd_par_r <= 1'b0;
         snap_r <= PATHS_RST;
         rd_data_r <= WORD_RST;
      end else begin
         wr_n_r <= wr_n_nxt;
         rd_act_r <= rd_act_nxt;
         rd_err_r <= rd_err_nxt;
         rd_par_r <= rd_par_nxt;
         snap_r <= snap_nxt;
         rd_data_r <= rd_data_nxt;
      end
   end

   // The pins are driven one cycle after the read begins, when data is
   // registered, and released one cycle after it ends.
   assign d_out = rd_data_r;
   assign d_oe = rd_act_r;

   // Configuration writes; generator and checker words never share state.
   always_comb begin
      gen_cfg_nxt = gen_cfg_r;
      chk_cfg_nxt = chk_cfg_r;
      err_en_nxt = err_en_r;
      par_en_nxt = par_en_r;
      if (wr_fire) begin
         if (hit_gen) begin
            gen_cfg_nxt = word_cfg(d_in);
            gen_cfg_nxt.rsvd = 1'b0; // No reserved bit in this word.
         end
         if (hit_chk) begin
            // The checker word keeps its reserved bit as written.
            chk_cfg_nxt = word_cfg(d_in);
         end
         if (hit_erren) begin
            err_en_nxt = d_in[NUM_PATHS-1:0];
         end
         if (hit_paren) begin
            par_en_nxt = d_in[NUM_PATHS-1:0];
         end
      end
   end

   // Configuration registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gen_cfg_r <= CFG_RST;
         chk_cfg_r <= CFG_RST;
         err_en_r <= PATHS_RST;
         par_en_r <= PATHS_RST;
      end else begin
         gen_cfg_r <= gen_cfg_nxt;
         chk_cfg_r <= chk_cfg_nxt;
         err_en_r <= err_en_nxt;
         par_en_r <= par_en_nxt;
      end
   end

   // Event flags. Only bits that were actually shown by a read are
   // cleared when the read ends, and a new event in that cycle wins,
   // so no event is lost between the read and its clear.
   always_comb begin
      // A flag rises only for an event seen on a locked path.
      err_set = evt.locked & evt.byte_err;
      par_set = evt.locked & evt.cmp_valid
         & (evt.cmp_mismatch ^ last_mis_r);
      last_mis_nxt = (last_mis_r & ~evt.cmp_valid)
         | (evt.cmp_mismatch & evt.cmp_valid);
      // A read ends when its register stops being read, even if the
      // strobe stays low and moves straight on to another register.
      clr_err = (rd_err_r && !(rd_act && hit_err)) ? snap_r
         : PATHS_RST;
      clr_par = (rd_par_r && !(rd_act && hit_par)) ? snap_r
         : PATHS_RST;
      err_flag_nxt = (err_flag_r & ~clr_err) | err_set;
      par_flag_nxt = (par_flag_r & ~clr_par) | par_set;
      irq_nxt = |(err_flag_r & err_en_r)
         || |(par_flag_r & par_en_r);
   end

   // Flag registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         err_flag_r <= PATHS_RST;
         par_flag_r <= PATHS_RST;
         last_mis_r <= PATHS_RST;
         irq_r <= 1'b0;
      end else begin
         err_flag_r <= err_flag_nxt;
         par_flag_r <= par_flag_nxt;
         last_mis_r <= last_mis_nxt;
         irq_r <= irq_nxt;
      end
   end

   // The interrupt is registered, so it follows its flag by one cycle.
   assign irq = irq_r;

   // Structure decode of each side.
   ptcfg_decode u_gen_dec (
      .clk(clk),
      .rst(rst),
      .cfg(gen_cfg_r),
      .paths(gen_paths)
   );

   ptcfg_decode u_chk_dec (
      .clk(clk),
      .rst(rst),
      .cfg(chk_cfg_r),
      .paths(chk_paths)
   );

   // Checks on the event flags, the interrupt and the bus.
   a_err_sets: assert property (
      @(posedge clk) disable iff (rst)
      (evt.locked[3] && evt.byte_err[3]) |=> err_flag_r[3])
      else $error("locked byte error did not set its flag");
   a_err_only_locked: assert property (
      @(posedge clk) disable iff (rst)
      1'b1 |=> ((err_flag_r & ~$past(err_flag_r)
         & ~$past(evt.locked & evt.byte_err)) == PATHS_RST))
      else $error("byte error flag rose without a locked event");
   a_par_repeat: assert property (
      @(posedge clk) disable iff (rst)
      (evt.cmp_valid[0] && evt.locked[0]
         && (evt.cmp_mismatch[0] == last_mis_r[0]) && !par_flag_r[0])
      |=> !par_flag_r[0])
      else $error("parity flag set on a repeated result");
   a_par_change: assert property (
      @(posedge clk) disable iff (rst)
      (evt.cmp_valid[5] && evt.locked[5]
         && (evt.cmp_mismatch[5] != last_mis_r[5])) |=> par_flag_r[5])
      else $error("parity change did not set its flag");
   a_clear_read: assert property (
      @(posedge clk) disable iff (rst)
      (rd_err_r && !(rd_act && hit_err) && err_set == PATHS_RST) |=>
         ((err_flag_r & $past(snap_r)) == PATHS_RST))
      else $error("read byte error flags were not cleared");
   a_irq_on: assert property (
      @(posedge clk) disable iff (rst)
      (|(err_flag_r & err_en_r)) |=> irq)
      else $error("enabled byte error flag gave no interrupt");
   a_par_irq: assert property (
      @(posedge clk) disable iff (rst)
      (|(par_flag_r & par_en_r)) |=> irq)
      else $error("enabled parity change flag gave no interrupt");
   a_irq_off: assert property (
      @(posedge clk) disable iff (rst)
      (!(|(err_flag_r & err_en_r)) && !(|(par_flag_r & par_en_r)))
      |=> !irq)
      else $error("interrupt without an enabled flag");
   a_bus_quiet: assert property (
      @(posedge clk) disable iff (rst)
      !sel |=> !d_oe)
      else $error("data pins driven for an unselected slice");
   a_side_apart: assert property (
      @(posedge clk) disable iff (rst)
      (wr_fire && hit_gen) |=> (chk_cfg_r == $past(chk_cfg_r)))
      else $error("generator write disturbed checker settings");
endmodule // ptcfg_top

// *** verif/test_pattern_tester_payload_cfg_irq.sv ***
`timescale 1ns/1ps
// Self-checking bench for one slice copy of the pattern tester config block.
module test_pattern_tester_payload_cfg_irq
   import ptcfg_pkg::*;
;
   localparam logic [1:0] SLICE = 2'h2; // A slice other than 0 proves the base.
   logic clk; // System clock.
   logic rst; // Asynchronous reset, active high.
   logic [ADDR_W-1:0] addr; // Register address.
   logic [DATA_W-1:0] d_in; // Write data.
   logic [DATA_W-1:0] d_out; // Read data.
   logic d_oe; // Data pin drive enable.
   logic rd_n; // Read strobe, active low.
   logic wr_n; // Write strobe, active low.
   logic tst; // Test register select, must be high to reach registers.
   logic blk_n; // Block select, active low.
   ptcfg_evt_s evt; // Per-path events from the checker datapath.
   ptcfg_path_s gen_paths; // Decoded generator structure.
   ptcfg_path_s chk_paths; // Decoded checker structure.
   logic irq; // Interrupt output.
   int miscompares; // Count of mismatches.
   int n_compared; // Count of comparisons.
   logic [15:0] q; // Last read data.
   logic oe; // Drive enable seen during the last read.

   ptcfg_top #(.SLICE_ID(SLICE)) dut_u (.clk(clk), .rst(rst), .addr(addr),
      .d_in(d_in), .d_out(d_out), .d_oe(d_oe), .rd_n(rd_n), .wr_n(wr_n),
      .test_reg_select_n(tst), .block_select_n(blk_n), .evt(evt),
      .gen_paths(gen_paths), .chk_paths(chk_paths), .irq(irq));

   // Free-running clock at 200 MHz.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Full address of an in-slice offset in this slice copy.
   function automatic logic [11:0] ad(input logic [9:0] ofs);
      return {SLICE, ofs};
   endfunction

   // Expected decode of a configuration word, worked out from the field map.
   function automatic ptcfg_path_s exp_paths(input logic [15:0] w);
      ptcfg_path_s e;
      e = '0;
      for (int p = 0; p < NUM_PATHS; p++) begin
         // Path p belongs to group (p mod 4) when no twelve-path concat.
         if (w[TWELVE_POS]) begin
            e.kind[p] = KIND_TWELVE;
         end else if (w[GROUP_POS + (p % GROUPS)]) begin
            e.kind[p] = KIND_GROUP3;
         end else begin
            e.kind[p] = KIND_STS1;
         end
      end
      // Without twelve-path concat the span field plays no part.
      e.span_bad = w[TWELVE_POS] & w[SPAN_POS+2];
      e.units = !w[TWELVE_POS] ? UNITS_ONE
         : e.span_bad ? UNITS_BAD : 3'(w[SPAN_POS +: 2]) + 3'h1;
      e.slave = w[SLAVE_POS] & w[TWELVE_POS];
      return e;
   endfunction

   // Compares two values and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One write: strobe low for one cycle, then high for one before returning.
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk);
      #1;
      addr = a;
      d_in = d;
      wr_n = 1'b0;
      @(posedge clk);
      #1;
      wr_n = 1'b1;
      @(posedge clk);
      #1;
   endtask

   // One read: strobe held low, data taken while it is still held.
   task automatic rd(input logic [11:0] a);
      @(posedge clk);
      #1;
      addr = a;
      rd_n = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      q = d_out;
      oe = d_oe;
      rd_n = 1'b1;
      // The clear on read lands after the strobe rises, so give it time.
      repeat (3) @(posedge clk);
      #1;
   endtask

   // Read that must be answered with the given word.
   task automatic rdc(input logic [9:0] ofs, input logic [15:0] exp);
      rd(ad(ofs));
      chk({31'h0, oe}, 32'h1);
      chk({16'h0, q}, {16'h0, exp});
   endtask

   // One-cycle event pulse with the given lock levels, then two cycles.
   task automatic pulse(input logic [11:0] lk, be, cv, cm);
      @(posedge clk);
      #1;
      evt.locked = lk;
      evt.byte_err = be;
      evt.cmp_valid = cv;
      evt.cmp_mismatch = cm;
      @(posedge clk);
      #1;
      evt.byte_err = '0;
      evt.cmp_valid = '0;
      repeat (2) @(posedge clk);
      #1;
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic conclude();
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Cuts a hang short; the tests need well under a tenth of this span.
   initial begin
      #50000;
      miscompares++;
      conclude();
   end

   // Main sequence.
   initial begin
      logic [9:0] ofs [6];
      logic [15:0] full [6];
      logic [15:0] wv [6];
      logic [15:0] cfg [9];
      logic [11:0] av [4];
      logic tv [4];
      logic bv [4];
      ofs = '{OFS_GEN_CFG, OFS_CHK_CFG, OFS_ERR_FLAG, OFS_ERR_EN,
              OFS_PAR_FLAG, OFS_PAR_EN};
      wv = '{16'hC700, 16'hC700, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
      full = '{16'hC700, 16'hC700, 16'h0000, 16'h0FFF, 16'h0000, 16'h0FFF};
      cfg = '{16'h0000, 16'h0005, 16'h000A, 16'h4000, 16'h4100, 16'h4200,
              16'hC300, 16'h4400, 16'h4700};
      av = '{12'h643, 12'hA43, 12'hA43, 12'hA48};
      tv = '{1'b1, 1'b0, 1'b1, 1'b1};
      bv = '{1'b0, 1'b0, 1'b1, 1'b0};
      miscompares = 0;
      n_compared = 0;
      addr = '0;
      d_in = '0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      tst = 1'b1;
      blk_n = 1'b0;
      evt = '0;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({31'h0, d_oe}, 32'h0);
      chk({3'h0, gen_paths}, {3'h0, exp_paths(16'h0000)});
      // Reset values, then the writable bits that software may set.
      for (int i = 0; i < 6; i++) rdc(ofs[i], 16'h0000);
      for (int i = 0; i < 6; i++) begin
         wr(ad(ofs[i]), wv[i]);
         rdc(ofs[i], full[i]);
      end
      $display("test registers done");
      // Generator and checker given the word list in opposite orders, decode compared.
      for (int i = 0; i < 9; i++) begin
         wr(ad(OFS_GEN_CFG), cfg[i]);
         wr(ad(OFS_CHK_CFG), cfg[8-i]);
         rdc(OFS_GEN_CFG, cfg[i]);
         chk({3'h0, gen_paths}, {3'h0, exp_paths(cfg[i])});
         chk({3'h0, chk_paths}, {3'h0, exp_paths(cfg[8-i])});
      end
      $display("test decode done");
      // Other slice, deselected block, unmapped offset: no answer, no write.
      wr(ad(OFS_CHK_CFG), 16'h0003);
      for (int i = 0; i < 4; i++) begin
         tst = tv[i];
         blk_n = bv[i];
         wr(av[i], 16'h000F);
         rd(av[i]);
         chk({31'h0, oe}, 32'h0);
         tst = 1'b1;
         blk_n = 1'b0;
         rdc(OFS_CHK_CFG, 16'h0003);
      end
      $display("test selects done");
      // Byte errors latch while disabled, only on locked paths.
      wr(ad(OFS_ERR_EN), 16'h0000);
      wr(ad(OFS_PAR_EN), 16'h0000);
      rd(ad(OFS_ERR_FLAG));
      rd(ad(OFS_PAR_FLAG));
      pulse(12'hA5A, 12'hFFF, 12'h000, 12'h000);
      chk({31'h0, irq}, 32'h0);
      rdc(OFS_ERR_FLAG, 16'h0A5A);
      rdc(OFS_ERR_FLAG, 16'h0000);
      wr(ad(OFS_ERR_EN), 16'h0008);
      pulse(12'hFFF, 12'h004, 12'h000, 12'h000);
      chk({31'h0, irq}, 32'h0);
      rdc(OFS_ERR_FLAG, 16'h0004);
      pulse(12'hFFF, 12'h008, 12'h000, 12'h000);
      chk({31'h0, irq}, 32'h1);
      rdc(OFS_ERR_FLAG, 16'h0008);
      chk({31'h0, irq}, 32'h0);
      $display("test byte errors done");
      // Comparison changes flag, repeats hold, unlocked results set no flag.
      pulse(12'hFFF, 12'h000, 12'hFFF, 12'h0F0);
      rdc(OFS_PAR_FLAG, 16'h00F0);
      pulse(12'hFFF, 12'h000, 12'hFFF, 12'h0F0);
      rdc(OFS_PAR_FLAG, 16'h0000);
      pulse(12'hFFF, 12'h000, 12'hFFF, 12'h000);
      rdc(OFS_PAR_FLAG, 16'h00F0);
      pulse(12'h000, 12'h000, 12'hFFF, 12'hFFF);
      rdc(OFS_PAR_FLAG, 16'h0000);
      wr(ad(OFS_PAR_EN), 16'h0800);
      pulse(12'hFFF, 12'h000, 12'hFFF, 12'h000);
      chk({31'h0, irq}, 32'h1);
      rdc(OFS_PAR_FLAG, 16'h0FFF);
      chk({31'h0, irq}, 32'h0);
      $display("test parity changes done");
      conclude();
   end
endmodule // test_pattern_tester_payload_cfg_irq
